// ### rtl/clock_rate_control.sv
// clock rate control: multiplier and divider registers, standby switching, system clock ticks
//
// The address map and strobed register access were left to the implementer.
`timescale 1ns/1ps
module clock_rate_control #(
    parameter int WAIT_UNIT = clk_ctrl_pkg::WAIT_UNIT_DEF
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [clk_ctrl_pkg::ADDR_W-1:0] regAddr,
    input wire logic [clk_ctrl_pkg::DATA_W-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [clk_ctrl_pkg::DATA_W-1:0] regRdata,
    input wire logic sleepReq,
    input wire logic wakeReq,
    output logic sysClkTick,
    output logic [1:0] activeMult,
    output logic [2:0] activeDiv,
    output logic standbyActive,
    output logic settling,
    output logic clkOutOff
);
    import clk_ctrl_pkg::*;

    // sixteen wait steps of WAIT_UNIT must fit the settling timer
    initial
    begin
        if (WAIT_UNIT < 1 || WAIT_UNIT * 16 >= (1 << WAIT_W))
            $error("clock_rate_control: WAIT_UNIT out of range");
    end

    core_state_s st_r; // whole block state
    core_state_s st_nxt; // next block state
    logic [2:0] curShift; // log2 of system clock period in cycles
    logic [WAIT_W-1:0] waitLoad; // settling cycles for the chosen wait
    logic settleLoad; // start the settling timer
    logic settleDone; // settling timer in its last cycle
    logic enterStandby; // sleep taken as software standby

    // period shift: clk is the x4 rate, so x1 costs two, x2 one
    function automatic logic [2:0] calc_shift(input logic [1:0] mult, input logic [2:0] div);
        logic [2:0] mShift;
        logic [2:0] dShift;
        mShift = 3'h0;
        dShift = 3'h0;
        if (mult == MULT_X1)
            mShift = 3'h2;
        else if (mult == MULT_X2)
            mShift = 3'h1;
        else
            mShift = 3'h0; // prohibited code 11 runs as x4
        dShift = (div > DIV_MAX) ? DIV_MAX : div;
        return mShift + dShift;
    endfunction

    assign curShift = calc_shift(st_r.activeMult, st_r.activeDiv);
    assign waitLoad = WAIT_W'(({1'b0, st_r.sby.exitWaitSel} + 5'h01) * WAIT_UNIT);
    assign enterStandby = sleepReq && st_r.sby.standbyOnSleep;

    // tick generator: stops outside normal running
    sysclk_tick_gen #(
        .CNT_W(TICK_CNT_W)
    ) u_tick (
        .clk(clk),
        .rst(rst),
        .run(st_r.state == ST_RUN),
        .shift(curShift),
        .tick(sysClkTick)
    );

    // settling wait after leaving standby
    settle_timer #(
        .W(WAIT_W)
    ) u_settle (
        .clk(clk),
        .rst(rst),
        .load(settleLoad),
        .loadValue(waitLoad),
        .done(settleDone)
    );

    // register writes, reads, standby sequencing and clock switching
    always_comb
    begin
        st_nxt = st_r;
        settleLoad = 1'b0;
        st_nxt.rdData = 8'h00;

        // register writes take effect at once, whatever the bus is doing
        if (regWr)
        begin
            if (regAddr == ADDR_PLL_CTRL)
            begin
                st_nxt.pll.resv3 = regWdata[PLL_RESV3_BIT];
                st_nxt.pll.multSel = regWdata[PLL_MULT_LSB +: 2];
            end
            else if (regAddr == ADDR_SYS_CTRL)
            begin
                st_nxt.sys.clkOutOff = regWdata[SYS_CLKOUT_OFF_BIT];
                st_nxt.sys.resv6 = regWdata[SYS_RESV6_BIT];
                st_nxt.sys.switchMode = regWdata[SYS_SWITCH_MODE_BIT];
                st_nxt.sys.divSel = regWdata[SYS_DIV_LSB +: 3];
            end
            else if (regAddr == ADDR_STANDBY_CTRL)
            begin
                st_nxt.sby.standbyOnSleep = regWdata[SBY_ON_SLEEP_BIT];
                st_nxt.sby.exitWaitSel = regWdata[SBY_WAIT_LSB +: 4];
            end
        end

        // reads: undriven bits and unmapped offsets return zero
        if (regRd)
        begin
            if (regAddr == ADDR_PLL_CTRL)
                st_nxt.rdData = {4'h0, st_r.pll.resv3, 1'b0, st_r.pll.multSel};
            else if (regAddr == ADDR_SYS_CTRL)
                st_nxt.rdData = {st_r.sys.clkOutOff, st_r.sys.resv6, 2'h0, st_r.sys.switchMode, st_r.sys.divSel};
            else if (regAddr == ADDR_STANDBY_CTRL)
                st_nxt.rdData = {st_r.sby.standbyOnSleep, 3'h0, st_r.sby.exitWaitSel};
            else
                st_nxt.rdData = 8'h00;
        end

        case (st_r.state)
            ST_RUN:
            begin
                if (enterStandby)
                    st_nxt.state = ST_STANDBY;
                else if (sysClkTick)
                begin
                    // switch only at a period end, so no phase is cut short
                    st_nxt.activeDiv = st_r.sys.divSel;
                    if (st_r.sys.switchMode)
                        st_nxt.activeMult = st_r.pll.multSel;
                end
                // deferred mode leaves activeMult alone here
            end
            ST_STANDBY:
            begin
                // clock is stopped: pending settings are safe to take
                st_nxt.activeMult = st_r.pll.multSel;
                st_nxt.activeDiv = st_r.sys.divSel;
                if (wakeReq)
                begin
                    settleLoad = 1'b1;
                    st_nxt.state = ST_SETTLE;
                end
            end
            ST_SETTLE:
            begin
                if (settleDone)
                    st_nxt.state = ST_RUN;
            end
            default:
            begin
                st_nxt.state = ST_RUN;
            end
        endcase
    end

    // state register
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            st_r <= CORE_STATE_RST;
        else
            st_r <= st_nxt;
    end

    // outputs, all from flip-flops except the tick
    assign regRdata = st_r.rdData;
    assign activeMult = st_r.activeMult;
    assign activeDiv = st_r.activeDiv;
    assign standbyActive = (st_r.state == ST_STANDBY);
    assign settling = (st_r.state == ST_SETTLE);
    assign clkOutOff = st_r.sys.clkOutOff;

    // helper: cycles spent in the settling state
    logic [WAIT_W-1:0] settleCnt;
    logic [WAIT_W-1:0] settleExpect;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            settleCnt <= '0;
            settleExpect <= '0;
        end
        else
        begin
            if (st_r.state == ST_SETTLE)
                settleCnt <= settleCnt + WAIT_W'(1);
            else
                settleCnt <= '0;
            if (settleLoad)
                settleExpect <= waitLoad;
        end
    end

    // sleep with standby bit set, then the clock stops
    sequence s_sleep_standby;
        st_r.state == ST_RUN && enterStandby;
    endsequence

    // wake from standby starts the settling wait
    sequence s_wake;
        st_r.state == ST_STANDBY && wakeReq;
    endsequence

    a_resv_high_zero: assert property (@(posedge clk) disable iff (rst)
        regRd && regAddr == ADDR_PLL_CTRL |=> regRdata[7:4] == 4'h0)
        else $error("multiplier register high bits not zero");

    a_resv3_stored: assert property (@(posedge clk) disable iff (rst)
        regWr && regAddr == ADDR_PLL_CTRL ##1 regRd && regAddr == ADDR_PLL_CTRL && !regWr
        |=> regRdata[3] == $past(regWdata[3], 2))
        else $error("multiplier bit 3 not stored");

    a_bit2_zero: assert property (@(posedge clk) disable iff (rst)
        regRd && regAddr == ADDR_PLL_CTRL |=> regRdata[2] == 1'b0)
        else $error("multiplier bit 2 not zero");

    a_deferred_hold: assert property (@(posedge clk) disable iff (rst)
        st_r.state == ST_RUN && !st_r.sys.switchMode |=> activeMult == $past(activeMult))
        else $error("deferred multiplier changed while running");

    a_standby_apply: assert property (@(posedge clk) disable iff (rst)
        s_sleep_standby ##1 !wakeReq |=> activeMult == $past(st_r.pll.multSel))
        else $error("pending multiplier not applied in standby");

    a_settle_length: assert property (@(posedge clk) disable iff (rst)
        settling && !st_nxt.state[1] |-> settleCnt + WAIT_W'(1) == settleExpect)
        else $error("settling wait has wrong length");

    a_wake_settles: assert property (@(posedge clk) disable iff (rst)
        s_wake |=> settling && !sysClkTick)
        else $error("wake did not enter settling");

    a_immediate_switch: assert property (@(posedge clk) disable iff (rst)
        st_r.state == ST_RUN && st_r.sys.switchMode && sysClkTick && !enterStandby
        |=> activeMult == $past(st_r.pll.multSel))
        else $error("immediate multiplier not applied");

    a_standby_enter: assert property (@(posedge clk) disable iff (rst)
        s_sleep_standby |=> standbyActive ##1 !sysClkTick)
        else $error("standby not entered on sleep");

    a_div_at_edge: assert property (@(posedge clk) disable iff (rst)
        activeDiv != $past(activeDiv) |-> $past(sysClkTick) || $past(standbyActive))
        else $error("divider changed off a clock boundary");

    a_no_tick_stopped: assert property (@(posedge clk) disable iff (rst)
        st_r.state != ST_RUN |-> !sysClkTick)
        else $error("system clock ticked while stopped");

endmodule // clock_rate_control

// ### rtl/clk_ctrl_pkg.sv
// shared constants, register layouts and state types of the clock rate control block
package clk_ctrl_pkg;

    // register port geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;

    // register offsets on the plain register port
    localparam logic [3:0] ADDR_PLL_CTRL = 4'h0;
    localparam logic [3:0] ADDR_SYS_CTRL = 4'h1;
    localparam logic [3:0] ADDR_STANDBY_CTRL = 4'h2;

    // field positions, multiplier control
    localparam int PLL_RESV3_BIT = 3;
    localparam int PLL_MULT_LSB = 0;

    // field positions, system clock control
    localparam int SYS_CLKOUT_OFF_BIT = 7;
    localparam int SYS_RESV6_BIT = 6;
    localparam int SYS_SWITCH_MODE_BIT = 3;
    localparam int SYS_DIV_LSB = 0;

    // field positions, standby control
    localparam int SBY_ON_SLEEP_BIT = 7;
    localparam int SBY_WAIT_LSB = 0;

    // multiplier select codes
    localparam logic [1:0] MULT_X1 = 2'h0;
    localparam logic [1:0] MULT_X2 = 2'h1;
    localparam logic [1:0] MULT_X4 = 2'h2;

    // highest legal divide select code (1/32)
    localparam logic [2:0] DIV_MAX = 3'h5;

    // widths of the tick counter and the settling timer
    localparam int TICK_CNT_W = 7;
    localparam int WAIT_W = 13;

    // multiplier control storage
    typedef struct packed {
        logic resv3;
        logic [1:0] multSel;
    } pll_ctrl_s;

    // system clock control storage
    typedef struct packed {
        logic clkOutOff;
        logic resv6;
        logic switchMode;
        logic [2:0] divSel;
    } sys_ctrl_s;

    // standby control storage
    typedef struct packed {
        logic standbyOnSleep;
        logic [3:0] exitWaitSel;
    } standby_ctrl_s;

    // operating state of the clock generator
    typedef enum logic [1:0] {
        ST_RUN,
        ST_STANDBY,
        ST_SETTLE
    } cg_state_e;

    // whole state of the main block
    typedef struct packed {
        cg_state_e state;
        pll_ctrl_s pll;
        sys_ctrl_s sys;
        standby_ctrl_s sby;
        logic [1:0] activeMult;
        logic [2:0] activeDiv;
        logic [7:0] rdData;
    } core_state_s;

    // reset values: all control fields start at zero, multiplier x1
    localparam pll_ctrl_s PLL_CTRL_RST = '{resv3: 1'b0, multSel: MULT_X1};
    localparam sys_ctrl_s SYS_CTRL_RST = '{clkOutOff: 1'b0, resv6: 1'b0, switchMode: 1'b0, divSel: 3'h0};
    localparam standby_ctrl_s SBY_CTRL_RST = '{standbyOnSleep: 1'b0, exitWaitSel: 4'h0};
    localparam core_state_s CORE_STATE_RST = '{
        state: ST_RUN,
        pll: PLL_CTRL_RST,
        sys: SYS_CTRL_RST,
        sby: SBY_CTRL_RST,
        activeMult: MULT_X1,
        activeDiv: 3'h0,
        rdData: 8'h00
    };

    // default settling unit in clock cycles per wait step
    localparam int WAIT_UNIT_DEF = 256;

endpackage

// ### rtl/sysclk_tick_gen.sv
// system clock tick generator: one tick every 2**shift clock cycles
`timescale 1ns/1ps
module sysclk_tick_gen #(
    parameter int CNT_W = clk_ctrl_pkg::TICK_CNT_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic run,
    input wire logic [2:0] shift,
    output logic tick
);
    import clk_ctrl_pkg::*;

    // the counter must reach the longest period, 2**7
    initial
    begin
        if (CNT_W < 7)
            $error("sysclk_tick_gen: CNT_W too small");
    end

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
    } tick_state_s;

    tick_state_s st_r; // phase counter
    tick_state_s st_nxt; // its next value
    logic [CNT_W-1:0] lastVal; // last count of a period

    // period end marks a clean clock boundary
    always_comb
    begin
        lastVal = CNT_W'((32'd1 << shift) - 32'd1);
        tick = run && (st_r.cnt == lastVal);
        st_nxt = st_r;
        if (!run)
            st_nxt.cnt = '0; // stopped clock restarts on a fresh period
        else if (tick)
            st_nxt.cnt = '0;
        else
            st_nxt.cnt = st_r.cnt + CNT_W'(1);
    end

    // state register
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

endmodule // sysclk_tick_gen

// ### rtl/settle_timer.sv
// down counter that times the settling wait after standby
`timescale 1ns/1ps
module settle_timer #(
    parameter int W = clk_ctrl_pkg::WAIT_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic load,
    input wire logic [W-1:0] loadValue,
    output logic done
);
    import clk_ctrl_pkg::*;

    typedef struct packed {
        logic [W-1:0] cnt;
    } timer_state_s;

    timer_state_s st_r; // remaining cycles
    timer_state_s st_nxt; // its next value

    // done in the last cycle of the wait
    always_comb
    begin
        done = (st_r.cnt == W'(1));
        st_nxt = st_r;
        if (load)
            st_nxt.cnt = loadValue;
        else if (st_r.cnt != '0)
            st_nxt.cnt = st_r.cnt - W'(1);
    end

    // state register
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

endmodule // settle_timer

// ### bench/tb_clock_rate_control.sv
// self-checking testbench of the clock rate control block
`timescale 1ns/1ps
module tb_clock_rate_control;
    import clk_ctrl_pkg::*;
    localparam int WU = 2; // short settling unit keeps the run brief
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] regAddr = 4'h0;
    logic [7:0] regWdata = 8'h00;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [7:0] regRdata;
    logic sleepReq = 1'b0;
    logic wakeReq = 1'b0;
    logic sysClkTick;
    logic [1:0] activeMult;
    logic [2:0] activeDiv;
    logic standbyActive;
    logic settling;
    logic clkOutOff;
    int n_errors = 0;
    int checked = 0;
    int cycles = 0;

    clock_rate_control #(.WAIT_UNIT(WU)) dut (.clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .sleepReq(sleepReq), .wakeReq(wakeReq),
        .sysClkTick(sysClkTick), .activeMult(activeMult), .activeDiv(activeDiv),
        .standbyActive(standbyActive), .settling(settling), .clkOutOff(clkOutOff));

    // 100 MHz clock
    initial
    begin
        forever #5 clk = ~clk;
    end

    // hang guard: far above the few hundred cycles the tests need
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            n_errors++;
            conclude();
        end
    end

    // count and report one comparison
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string msg);
        checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    // one-cycle write strobe
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask

    // one-cycle read strobe, data taken in the following cycle only
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1 d = regRdata;
    endtask

    // read and compare in one go
    task automatic rdc(input logic [3:0] a, input logic [7:0] exp, input string msg);
        logic [7:0] d;
        rd(a, d);
        cmp(d, exp, msg);
    endtask

    // write strobe then read strobe back to back, data taken after the read
    task automatic wrrd(input logic [3:0] a, input logic [7:0] d, input logic [7:0] exp, input string msg);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWr <= 1'b0;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1 cmp(regRdata, exp, msg);
    endtask

    // cycles between two ticks, sampled after each edge settles
    task automatic period(output int p);
        int n;
        n = 0;
        do begin @(posedge clk); #1 n++; end while (sysClkTick !== 1'b1 && n < 100);
        p = 0;
        do begin @(posedge clk); #1 p++; end while (sysClkTick !== 1'b1 && p < 100);
    endtask

    // one-cycle pulse on sleep or wake
    task automatic pulse(input bit sleep);
        @(posedge clk);
        if (sleep) sleepReq <= 1'b1; else wakeReq <= 1'b1;
        @(posedge clk);
        sleepReq <= 1'b0;
        wakeReq <= 1'b0;
        #1;
    endtask

    // reset values of the multiplier, and the fixed bits of the multiplier and system control registers
    task automatic t_regs();
        cmp({6'h0, activeMult}, 8'h00, "mult after reset");
        rdc(ADDR_PLL_CTRL, 8'h00, "pll reset value");
        // bit 3 set once only, to show that it is stored; select code kept legal
        wrrd(ADDR_PLL_CTRL, 8'hFE, 8'h0A, "pll fixed bits");
        wr(ADDR_PLL_CTRL, 8'h00);
        rdc(ADDR_PLL_CTRL, 8'h00, "pll clear");
        wr(ADDR_SYS_CTRL, 8'hB8);
        rdc(ADDR_SYS_CTRL, 8'h88, "sys fixed bits");
        cmp({7'h0, clkOutOff}, 8'h01, "clock output off bit");
        wr(4'h7, 8'hFF);
        rdc(4'h7, 8'h00, "unmapped read");
    endtask

    // immediate switching through every legal multiplier code
    task automatic t_mult();
        logic [1:0] codes [3] = '{MULT_X2, MULT_X4, MULT_X1};
        int sh [3] = '{1, 0, 2};
        int p;
        int n;
        wr(ADDR_SYS_CTRL, 8'h08);
        foreach (codes[i])
        begin
            wr(ADDR_PLL_CTRL, {6'h0, codes[i]});
            n = 0;
            while (activeMult !== codes[i] && n < 40) begin @(posedge clk); #1 n++; end
            cmp({6'h0, activeMult}, {6'h0, codes[i]}, "immediate mult");
            period(p);
            cmp(8'(p), 8'(1 << sh[i]), "mult tick period");
        end
    endtask

    // every legal divide code at x4, from 1/32 down so each code is a change; it must land on a tick cycle
    task automatic t_div();
        int p;
        int n;
        logic prevTick;
        wr(ADDR_PLL_CTRL, {6'h0, MULT_X4});
        for (int d = 5; d >= 0; d--)
        begin
            wr(ADDR_SYS_CTRL, 8'h08 | 8'(d));
            #1;
            n = 0;
            prevTick = 1'b0;
            while (activeDiv !== 3'(d) && n < 100)
            begin
                prevTick = sysClkTick;
                @(posedge clk);
                #1 n++;
            end
            cmp({7'h0, prevTick}, 8'h01, "divider change off boundary");
            period(p);
            cmp(8'(p), 8'(1 << d), "divided tick period");
        end
        wr(ADDR_SYS_CTRL, 8'h00);
    endtask

    // deferred switching through standby and the settling wait
    task automatic t_standby();
        int n;
        int p;
        repeat (40) @(posedge clk);
        #1;
        n = activeDiv;
        cmp(8'(n), 8'h00, "divider back to 1/1");
        wr(ADDR_STANDBY_CTRL, 8'h01);
        wr(ADDR_PLL_CTRL, {6'h0, MULT_X2});
        repeat (40) @(posedge clk);
        #1;
        cmp({6'h0, activeMult}, {6'h0, MULT_X4}, "deferred mult held");
        pulse(1);
        repeat (3) @(posedge clk);
        #1;
        cmp({7'h0, standbyActive}, 8'h00, "sleep without standby bit");
        wr(ADDR_STANDBY_CTRL, 8'h81);
        rdc(ADDR_STANDBY_CTRL, 8'h81, "standby ctrl");
        pulse(1);
        cmp({7'h0, standbyActive}, 8'h01, "standby entered");
        n = 0;
        repeat (10)
        begin
            @(posedge clk);
            #1 n += sysClkTick;
        end
        cmp(8'(n), 8'h00, "ticks in standby");
        cmp({6'h0, activeMult}, {6'h0, MULT_X2}, "mult applied in standby");
        pulse(0);
        cmp({6'h0, standbyActive, settling}, 8'h01, "settling after wake");
        n = 0;
        while (settling === 1'b1 && n < 100) begin @(posedge clk); #1 n++; end
        cmp(8'(n), 8'((1 + 1) * WU), "settling length");
        period(p);
        cmp(8'(p), 8'h02, "x2 period after wake");
    endtask

    // verdict and end of run
    task automatic conclude();
        $display("errors %0d, checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // main sequence
    initial
    begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        t_regs();
        t_mult();
        t_div();
        t_standby();
        conclude();
    end
endmodule // tb_clock_rate_control
